// file: inc/rank_regs_pkg.sv
package rank_regs_pkg;

    // ----------------------------------------------------------------
    // register offsets on the microprocessor port
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_RANK_PAIR_ONE_TWO    = 8'h18;
    localparam logic [7:0] ADDR_RANK_PAIR_THREE_FOUR = 8'h19;
    localparam logic [7:0] ADDR_SOURCE_SELECT        = 8'h4B;

    // ----------------------------------------------------------------
    // field positions, rank width and input count
    // ----------------------------------------------------------------
    localparam int BANK_SELECT_BIT = 4;
    localparam int RANK_WIDTH      = 4;
    localparam int NUM_INPUTS      = 4;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_MAIN_PAIR_ONE_TWO    = 8'h32;
    localparam logic [7:0] RST_AUX_PAIR_ONE_TWO     = 8'h00;
    localparam logic [7:0] RST_MAIN_PAIR_THREE_FOUR = 8'h54;
    localparam logic [7:0] RST_AUX_PAIR_THREE_FOUR  = 8'h00;
    localparam logic       RST_BANK_SELECT          = 1'b0;

    // ----------------------------------------------------------------
    // special codes
    // ----------------------------------------------------------------
    localparam logic [3:0] RANK_EXCLUDED = 4'h0;
    localparam logic [2:0] NO_INPUT      = 3'h0;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

endpackage : rank_regs_pkg

// file: rtl/reference_input_priority_regs.sv
// Functional notes
// R1: pair one-two: input two [7:4], one [3:0]
// R2: pair three-four: input four [7:4], three [3:0]
// R3: smaller rank value means higher priority
// R4: rank zero excludes input; 1-15 rank it
// R5: bank bit selects main or auxiliary copy
// R6: pair three-four resets 0x54 main, 0x00 auxiliary
// R7: written values are stored and read back
// R8: access touches only the currently selected copy
`timescale 1ns/1ps
`default_nettype none

module reference_input_priority_regs (
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    // microprocessor port
    input  wire logic [7:0] i_addr,
    input  wire logic       i_wr_stb,
    input  wire logic       i_rd_stb,
    input  wire logic [7:0] i_wr_data,
    output logic      [7:0] o_rd_data,
    output logic            o_rd_valid,
    // selection results
    output logic            o_bank_select,
    output logic      [2:0] o_main_best_input,
    output logic      [2:0] o_aux_best_input
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // rank of input k (1..4) in a packed vector of four ranks
    function automatic logic [3:0] rank_of(input logic [15:0] r, input logic [2:0] k);
        logic [3:0] v;
        case (k)
            3'h1:    v = r[3:0];
            3'h2:    v = r[7:4];
            3'h3:    v = r[11:8];
            3'h4:    v = r[15:12];
            default: v = rank_regs_pkg::RANK_EXCLUDED;
        endcase
        return v;
    endfunction : rank_of

    // a beats b when a is enabled and b is excluded or larger
    function automatic logic beats(input logic [3:0] a, input logic [3:0] b);
        return (a != rank_regs_pkg::RANK_EXCLUDED) &&
               ((b == rank_regs_pkg::RANK_EXCLUDED) || (a < b));
    endfunction : beats

    // best enabled input, lower index wins a tie, zero when none
    function automatic logic [2:0] best_of(input logic [15:0] r);
        logic [2:0] best;
        logic [3:0] cand;
        best = rank_regs_pkg::NO_INPUT;
        for (int i = 1; i <= rank_regs_pkg::NUM_INPUTS; i++) begin
            cand = rank_of(r, 3'(i));
            if (beats(cand, rank_of(r, best))) begin
                best = 3'(i);
            end
        end
        return best;
    endfunction : best_of

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0] main_pair12_reg;
    logic [7:0] aux_pair12_reg;
    logic [7:0] main_pair34_reg;
    logic [7:0] aux_pair34_reg;
    logic       bank_reg;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire logic        hit_pair12 = (i_addr == rank_regs_pkg::ADDR_RANK_PAIR_ONE_TWO);
    wire logic        hit_pair34 = (i_addr == rank_regs_pkg::ADDR_RANK_PAIR_THREE_FOUR);
    wire logic        hit_select = (i_addr == rank_regs_pkg::ADDR_SOURCE_SELECT);
    wire logic        wr_main12  = i_wr_stb && hit_pair12 && !bank_reg; // R5 R8
    wire logic        wr_aux12   = i_wr_stb && hit_pair12 &&  bank_reg; // R5 R8
    wire logic        wr_main34  = i_wr_stb && hit_pair34 && !bank_reg; // R5 R8
    wire logic        wr_aux34   = i_wr_stb && hit_pair34 &&  bank_reg; // R5 R8
    wire logic        wr_select  = i_wr_stb && hit_select;
    wire logic [15:0] main_ranks = {main_pair34_reg, main_pair12_reg}; // R1 R2
    wire logic [15:0] aux_ranks  = {aux_pair34_reg, aux_pair12_reg};   // R1 R2

    // read selection follows the bank bit at the time of the read
    wire logic [7:0]  pair12_sel = bank_reg ? aux_pair12_reg : main_pair12_reg; // R5 R8
    wire logic [7:0]  pair34_sel = bank_reg ? aux_pair34_reg : main_pair34_reg; // R5 R8
    wire logic [7:0]  select_rd  = {3'h0, bank_reg, 4'h0};
    wire logic [7:0]  rd_mux     = hit_pair12 ? pair12_sel :
                                   hit_pair34 ? pair34_sel :
                                   hit_select ? select_rd  :
                                   rank_regs_pkg::READ_UNMAPPED; // R7

    // ----------------------------------------------------------------
    // rank registers, both copies
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            main_pair12_reg <= rank_regs_pkg::RST_MAIN_PAIR_ONE_TWO;
            aux_pair12_reg  <= rank_regs_pkg::RST_AUX_PAIR_ONE_TWO;
            main_pair34_reg <= rank_regs_pkg::RST_MAIN_PAIR_THREE_FOUR; // R6
            aux_pair34_reg  <= rank_regs_pkg::RST_AUX_PAIR_THREE_FOUR;  // R6
        end else begin
            if (wr_main12) main_pair12_reg <= i_wr_data; // R7
            if (wr_aux12)  aux_pair12_reg  <= i_wr_data; // R7
            if (wr_main34) main_pair34_reg <= i_wr_data; // R7
            if (wr_aux34)  aux_pair34_reg  <= i_wr_data; // R7
        end
    end

    // bank select bit, other bits of that register read zero
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            bank_reg <= rank_regs_pkg::RST_BANK_SELECT;
        end else if (wr_select) begin
            bank_reg <= i_wr_data[rank_regs_pkg::BANK_SELECT_BIT]; // R5
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rd_data  <= rank_regs_pkg::READ_UNMAPPED;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_data  <= i_rd_stb ? rd_mux : rank_regs_pkg::READ_UNMAPPED; // R7
            o_rd_valid <= i_rd_stb;
        end
    end

    // best input per path, smallest enabled rank
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_main_best_input <= rank_regs_pkg::NO_INPUT;
            o_aux_best_input  <= rank_regs_pkg::NO_INPUT;
        end else begin
            o_main_best_input <= best_of(main_ranks); // R3 R4
            o_aux_best_input  <= best_of(aux_ranks);  // R3 R4
        end
    end

    // bank bit mirrored out
    assign o_bank_select = bank_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    // smallest enabled rank, for checking the choice
    function automatic logic [3:0] min_enabled(input logic [15:0] r);
        logic [3:0] m;
        m = rank_regs_pkg::RANK_EXCLUDED;
        for (int i = 1; i <= rank_regs_pkg::NUM_INPUTS; i++) begin
            if (beats(rank_of(r, 3'(i)), m)) m = rank_of(r, 3'(i));
        end
        return m;
    endfunction : min_enabled

    pair12_fields_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R1
        wr_main12 |=> rank_of(main_ranks, 3'h1) == $past(i_wr_data[3:0]) &&
                      rank_of(main_ranks, 3'h2) == $past(i_wr_data[7:4]))
        else $error("pair one-two fields misplaced");

    pair34_fields_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R2
        wr_aux34 |=> rank_of(aux_ranks, 3'h3) == $past(i_wr_data[3:0]) &&
                     rank_of(aux_ranks, 3'h4) == $past(i_wr_data[7:4]))
        else $error("pair three-four fields misplaced");

    best_smallest_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R3
        ##1 (o_main_best_input != rank_regs_pkg::NO_INPUT) |->
            rank_of($past(main_ranks), o_main_best_input) == min_enabled($past(main_ranks)))
        else $error("main choice is not the smallest rank");

    zero_excluded_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R4
        ##1 (o_aux_best_input == rank_regs_pkg::NO_INPUT) == ($past(aux_ranks) == 16'h0000))
        else $error("auxiliary choice ignores zero ranks wrongly");

    bank_read_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R5
        (i_rd_stb && hit_pair12 && bank_reg) |=> o_rd_valid && o_rd_data == $past(aux_pair12_reg))
        else $error("auxiliary copy not read with bank set");

    reset_values_a: assert property (@(posedge i_sys_clk) // R6
        $fell(i_rst) |-> main_pair34_reg == 8'h54 && aux_pair34_reg == 8'h00)
        else $error("pair three-four reset values wrong");

    write_readback_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R7
        (i_wr_stb && hit_pair34 && !wr_select) ##1 (i_rd_stb && hit_pair34 && !i_wr_stb)
        |=> o_rd_data == $past(i_wr_data, 2))
        else $error("written value not read back");

    other_copy_kept_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R8
        wr_main12 |=> $stable(aux_pair12_reg))
        else $error("write disturbed the other copy");

    cover_aux_write_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
        wr_select ##1 (bank_reg && wr_aux12));
    cover_none_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
        o_main_best_input == rank_regs_pkg::NO_INPUT);
    cover_input_four_c: cover property (@(posedge i_sys_clk) disable iff (i_rst)
        o_aux_best_input == 3'h4);

endmodule : reference_input_priority_regs

`default_nettype wire

// file: dv/tb_reference_input_priority_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tb_reference_input_priority_regs;

    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic       i_sys_clk = 1'b0;
    logic       i_rst     = 1'b1;
    logic [7:0] i_addr    = 8'h00;
    logic       i_wr_stb  = 1'b0;
    logic       i_rd_stb  = 1'b0;
    logic [7:0] i_wr_data = 8'h00;
    logic [7:0] o_rd_data;
    logic       o_rd_valid;
    logic       o_bank_select;
    logic [2:0] o_main_best_input;
    logic [2:0] o_aux_best_input;
    int         err_count = 0;
    int         n_checks  = 0;
    int         cycles    = 0;

    // 200 MHz clock
    always #2.5 i_sys_clk = ~i_sys_clk;

    reference_input_priority_regs dut (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .i_wr_data(i_wr_data),
        .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
        .o_bank_select(o_bank_select), .o_main_best_input(o_main_best_input),
        .o_aux_best_input(o_aux_best_input)
    );

    // ----------------------------------------------------------------
    // report, compare and access tasks
    // ----------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    task automatic mismatch(input string msg);
        err_count++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask : mismatch

    // read port result; an idle port shows valid low and data zero
    task automatic chk_rd(input logic [7:0] exp, input logic v = 1'b1);
        n_checks++;
        if (o_rd_valid !== v || o_rd_data !== exp) mismatch("read data");
    endtask : chk_rd

    task automatic chk_sel(input logic [2:0] m, input logic [2:0] a);
        @(posedge i_sys_clk);
        #1;
        n_checks++;
        if (o_main_best_input !== m || o_aux_best_input !== a) mismatch("best input");
    endtask : chk_sel

    task automatic chk_bank(input logic b);
        n_checks++;
        if (o_bank_select !== b) mismatch("bank select");
    endtask : chk_bank

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        #1 {i_addr, i_wr_data, i_wr_stb} = {a, d, 1'b1};
        @(posedge i_sys_clk);
        #1 i_wr_stb = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_sys_clk);
        #1 {i_addr, i_rd_stb} = {a, 1'b1};
        @(posedge i_sys_clk);
        #1 i_rd_stb = 1'b0;
        chk_rd(exp);
    endtask : rd

    task automatic do_reset();
        i_rst = 1'b1;
        repeat (8) @(posedge i_sys_clk);
        #1 i_rst = 1'b0;
    endtask : do_reset

    // cut a hang short
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        do_reset();
        rd(8'h18, 8'h32);
        rd(8'h19, 8'h54);
        chk_bank(1'b0);
        chk_sel(3'h1, 3'h0);
        wr(8'h4B, 8'hFF);
        chk_bank(1'b1);
        rd(8'h4B, 8'h10);
        rd(8'h18, 8'h00);
        rd(8'h19, 8'h00);
        wr(8'h19, 8'h21);
        chk_sel(3'h1, 3'h3);
        rd(8'h19, 8'h21);
        wr(8'h18, 8'h0F);
        chk_sel(3'h1, 3'h3);
        wr(8'h4B, 8'h00);
        chk_bank(1'b0);
        rd(8'h19, 8'h54);
        rd(8'h18, 8'h32);
        wr(8'h18, 8'h00);
        chk_sel(3'h3, 3'h3);
        wr(8'h19, 8'h60);
        chk_sel(3'h4, 3'h3);
        wr(8'h18, 8'h70);
        chk_sel(3'h4, 3'h3);
        wr(8'h18, 8'h50);
        chk_sel(3'h2, 3'h3);
        // read and write in one cycle: read sees the old value
        @(posedge i_sys_clk);
        #1 {i_addr, i_wr_data, i_wr_stb, i_rd_stb} = {8'h18, 8'hA5, 2'b11};
        @(posedge i_sys_clk);
        #1 {i_wr_stb, i_rd_stb} = 2'b00;
        chk_rd(8'h50);
        rd(8'h18, 8'hA5);
        wr(8'h20, 8'hFF);
        chk_rd(8'h00, 1'b0);
        rd(8'h20, 8'h00);
        rd(8'h19, 8'h60);
        // back to back: write then read, bank write then auxiliary write
        @(posedge i_sys_clk);
        #1 {i_addr, i_wr_data, i_wr_stb} = {8'h19, 8'h87, 1'b1};
        @(posedge i_sys_clk);
        #1 {i_wr_stb, i_rd_stb} = 2'b01;
        @(posedge i_sys_clk);
        #1 {i_addr, i_wr_data, i_wr_stb, i_rd_stb} = {8'h4B, 8'h10, 2'b10};
        chk_rd(8'h87);
        @(posedge i_sys_clk);
        #1 {i_addr, i_wr_data} = {8'h18, 8'h99};
        @(posedge i_sys_clk);
        #1 i_wr_stb = 1'b0;
        rd(8'h18, 8'h99);
        do_reset();
        rd(8'h19, 8'h54);
        wr(8'h4B, 8'h10);
        rd(8'h19, 8'h00);
        final_report();
    end

endmodule : tb_reference_input_priority_regs

`default_nettype wire
